// *** verilog/ldc_pkg.sv ***
// ldc_pkg: constants, field layouts and types for the laser drive and
// bus address configuration bank behind the 2-wire management port.
// assumes one 20 MHz clock and a synchronous active-low reset.
// Operation
// [R1] write to drive config aborts running conversion
// [R2] converter restarts sequence once write completes
// [R3] drive config bits survive power and reset
// [R4] address config bits survive power and reset
// [R5] access only under valid manufacturer password
// [R6] without password writes ignored, contents kept
// [R7] device page at A6h, drive config byte 01h
// [R8] address config register at byte 02h
// [R9] bit 7 selects follower or inverted op-amp
// [R10] bit 6 selects quarter or full setpoint swing
// [R11] bit 5 references feedback to supply or ground
// [R12] bits 4:2 pick internal feedback resistor
// [R13] bit 1 selects bias source or sink
// [R14] bit 0 sets shutdown output active level
// [R15] top nibble is serial address, default 1010
// [R16] new address nibble takes effect at once
// [R17] host then uses the newly programmed address
// [R18] low three bits set reset-field clear delay
package ldc_pkg;
    // register byte offsets on the device page
    localparam logic [7:0] CFG1_OFFSET = 8'h01;
    localparam logic [7:0] CFG2_OFFSET = 8'h02;
    // stored values after a factory initialisation
    localparam logic [7:0] CFG1_RESET = 8'h02;
    localparam logic [7:0] CFG2_RESET = 8'ha2;
    // low three bits of the 7-bit device address (page A6h = 1010_011x)
    localparam logic [2:0] DEV_ADDR_LOW = 3'h3;
    // field positions in the drive config byte
    localparam int INV_POS = 7;
    localparam int SWING_POS = 6;
    localparam int REF_POS = 5;
    localparam int RFB_LSB = 2;
    localparam int DIR_POS = 1;
    localparam int POL_POS = 0;
    // field positions in the address config byte
    localparam int NIBBLE_LSB = 4;
    localparam int DELAY_LSB = 0;
    // value read back for unmapped or locked bytes
    localparam logic [7:0] READ_EMPTY = 8'h00;

    // drive config byte, msb first as stored
    typedef struct packed {
        logic apc_input_invert; // 0 follower, 1 inverted
        logic setpoint_swing_quarter; // 1 quarter scale, 0 full
        logic feedback_reference_select; // 1 supply, 0 analog ground
        logic [2:0] feedback_resistor_select; // 000 open, doubling
        logic bias_drive_direction; // 1 source, 0 sink
        logic shutdown_polarity; // 1 active high
    } ldc_cfg1_t;

    // address config byte
    typedef struct packed {
        logic [3:0] serial_address_high_nibble; // upper address nibble
        logic spare; // plain storage bit
        logic [2:0] reset_field_clear_delay; // clear delay code
    } ldc_cfg2_t;

    // serial slave states
    typedef enum logic [3:0] {
        LDC_IDLE, LDC_ADDR, LDC_ADDR_ACK, LDC_PTR, LDC_PTR_ACK,
        LDC_WDATA, LDC_WDATA_ACK, LDC_RDATA, LDC_RDATA_ACK
    } ldc_state_t;
endpackage

// *** verilog/ldc_sync.sv ***
// ldc_sync: two-flop synchroniser for the bus pins.
// assumes idle-high open-drain lines, so both stages reset to one.
`timescale 1ns/10ps
module ldc_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // asynchronous pins in, synchronous copy out
    input wire logic [1:0] pin_in,
    output logic [1:0] pin_sync
);
    logic [1:0] meta; // first stage, read by second stage only
    logic [1:0] next_meta;
    logic [1:0] next_pin_sync;

    // next values of both stages
    always_comb begin
        next_meta = pin_in;
        next_pin_sync = meta;
        if (!rstn) begin
            next_meta = 2'h3;
            next_pin_sync = 2'h3;
        end
    end

    // register the stages
    always_ff @(posedge clk) begin
        meta <= next_meta;
        pin_sync <= next_pin_sync;
    end
endmodule // ldc_sync

// *** verilog/ldc_nv_store.sv ***
// ldc_nv_store: the two non-volatile configuration bytes.
// assumes the array is loaded once by factory_init; the system reset
// does not touch it, so values stand through every reset.
`timescale 1ns/10ps
module ldc_nv_store (
    // clock
    input wire logic clk,
    // one-cycle pulse that loads the factory values
    input wire logic factory_init,
    // write port from the serial slave
    input wire logic wr_en,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    // manufacturer password in force
    input wire logic password_ok,
    // stored contents
    output ldc_pkg::ldc_cfg1_t cfg1,
    output ldc_pkg::ldc_cfg2_t cfg2
);
    import ldc_pkg::*;
    ldc_cfg1_t next_cfg1;
    ldc_cfg2_t next_cfg2;

    // write decode; locked writes leave the cells alone
    always_comb begin
        next_cfg1 = cfg1;
        next_cfg2 = cfg2;
        if (factory_init) begin
            next_cfg1 = ldc_cfg1_t'(CFG1_RESET);
            next_cfg2 = ldc_cfg2_t'(CFG2_RESET); // [R15]
        end else if (wr_en && password_ok) begin // [R5] [R6]
            if (wr_addr == CFG1_OFFSET) begin // [R7]
                next_cfg1 = ldc_cfg1_t'(wr_data);
            end
            if (wr_addr == CFG2_OFFSET) begin // [R8]
                next_cfg2 = ldc_cfg2_t'(wr_data);
            end
        end
    end

    // cells without reset: contents kept over resets [R3] [R4]
    always_ff @(posedge clk) begin
        cfg1 <= next_cfg1;
        cfg2 <= next_cfg2;
    end
endmodule // ldc_nv_store

// *** verilog/ldc_top.sv ***
// ldc_top: 2-wire management slave serving the drive config and
// address config bytes, with converter abort/restart and shutdown level.
// assumes an open-drain bus resolved outside and a password checker on
// the same clock that raises password_ok while the password is valid.
`timescale 1ns/10ps
module ldc_top (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // factory load of the non-volatile bytes
    input wire logic factory_init,
    // password state from the access checker
    input wire logic password_ok,
    // serial bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // converter control
    output logic adc_abort,
    output logic adc_restart,
    // shutdown request from the fault logic, and the pin it drives
    input wire logic shutdown_request,
    output logic shutdown_output,
    // configuration to the analog loop
    output logic apc_input_invert,
    output logic setpoint_swing_quarter,
    output logic feedback_reference_select,
    output logic [2:0] feedback_resistor_select,
    output logic bias_drive_direction,
    output logic shutdown_polarity,
    // address nibble and reset-field clear delay
    output logic [3:0] serial_address_high_nibble,
    output logic [2:0] reset_field_clear_delay
);
    import ldc_pkg::*;

    // synchronised pins and their previous samples
    logic [1:0] pins_s; // {scl, sda} after two flops
    logic scl_s;
    logic sda_s;
    logic scl_q;
    logic sda_q;

    // stored bytes
    ldc_cfg1_t cfg1;
    ldc_cfg2_t cfg2;

    // slave state
    ldc_state_t state;
    ldc_state_t next_state;
    logic [2:0] bit_cnt; // bits seen in current byte
    logic [2:0] next_bit_cnt;
    logic [7:0] shreg; // shift register, in or out
    logic [7:0] next_shreg;
    logic [7:0] ptr; // byte pointer, auto-increments
    logic [7:0] next_ptr;
    logic rw; // 1 while the frame is a read
    logic next_rw;
    logic ack_half; // second half of an ack bit
    logic next_ack_half;
    logic master_nack; // host refused further read bytes
    logic next_master_nack;
    logic next_sda_oe;
    logic cfg1_dirty; // accepted drive config write in frame
    logic next_cfg1_dirty;
    logic next_adc_abort;
    logic next_adc_restart;
    logic next_shutdown_output;
    logic wr_en; // write strobe to the store
    logic next_wr_en;
    logic [7:0] wr_addr;
    logic [7:0] next_wr_addr;
    logic [7:0] wr_data;
    logic [7:0] next_wr_data;

    // bus events
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic [6:0] my_addr; // live 7-bit device address
    logic [7:0] wbyte; // byte as completed on the 8th rise

    // byte presented for a read; locked or unmapped bytes read empty
    function automatic logic [7:0] read_byte(input logic [7:0] addr,
        input ldc_cfg1_t c1,
        input ldc_cfg2_t c2,
        input logic pw);
        logic [7:0] val;
        val = READ_EMPTY;
        if (pw && addr == CFG1_OFFSET) begin // [R5] [R7]
            val = c1;
        end
        if (pw && addr == CFG2_OFFSET) begin // [R5] [R8]
            val = c2;
        end
        return val;
    endfunction

    // pin synchroniser, both lines through two flops
    ldc_sync u_sync (
        .clk(clk),
        .rstn(rstn),
        .pin_in({scl_in, sda_in}),
        .pin_sync(pins_s)
    );

    // non-volatile configuration bytes
    ldc_nv_store u_store (
        .clk(clk),
        .factory_init(factory_init),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .password_ok(password_ok),
        .cfg1(cfg1),
        .cfg2(cfg2)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    // edge and condition detection on the synchronised lines
    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    assign start_cond = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_cond = scl_s & scl_q & ~sda_q & sda_s;
    assign wbyte = {shreg[6:0], sda_s};

    // address compared straight from the stored nibble, so a new
    // nibble is matched from the very next frame [R15] [R16] [R17]
    assign my_addr = {cfg2.serial_address_high_nibble, DEV_ADDR_LOW}; // [R7]

    // config fields: wires from the store's own flops [R9] [R10] [R11]
    assign apc_input_invert = cfg1.apc_input_invert; // [R9]
    assign setpoint_swing_quarter = cfg1.setpoint_swing_quarter; // [R10]
    assign feedback_reference_select = cfg1.feedback_reference_select; // [R11]
    assign feedback_resistor_select = cfg1.feedback_resistor_select; // [R12]
    assign bias_drive_direction = cfg1.bias_drive_direction; // [R13]
    assign shutdown_polarity = cfg1.shutdown_polarity;
    assign serial_address_high_nibble = cfg2.serial_address_high_nibble; // [R15]
    assign reset_field_clear_delay = cfg2.reset_field_clear_delay; // [R18]

    // next-state logic of the serial slave
    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_ptr = ptr;
        next_rw = rw;
        next_ack_half = ack_half;
        next_master_nack = master_nack;
        next_sda_oe = sda_oe;
        next_cfg1_dirty = cfg1_dirty;
        next_adc_abort = 1'b0;
        next_adc_restart = 1'b0;
        next_wr_en = 1'b0;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        // shutdown pin follows the request at the programmed level
        next_shutdown_output = cfg1.shutdown_polarity ? shutdown_request
            : ~shutdown_request; // [R14]
        if (stop_cond) begin
            // end of frame: the write is complete, restart the sequence if the drive config was written
            next_state = LDC_IDLE;
            next_sda_oe = 1'b0;
            next_ack_half = 1'b0;
            if (cfg1_dirty) begin
                next_adc_restart = 1'b1; // [R2]
                next_cfg1_dirty = 1'b0;
            end
        end else if (start_cond) begin
            // start or repeated start: new address byte follows
            next_state = LDC_ADDR;
            next_bit_cnt = 3'h0;
            next_sda_oe = 1'b0;
            next_ack_half = 1'b0;
        end else begin
            unique case (state)
                LDC_IDLE: begin
                    // wait for a start, bus released
                    next_sda_oe = 1'b0;
                end
                LDC_ADDR, LDC_PTR, LDC_WDATA: begin
                    // shift a byte in on rising edges
                    if (scl_rise) begin
                        next_shreg = wbyte;
                        next_bit_cnt = bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7) begin
                            next_ack_half = 1'b0;
                            if (state == LDC_ADDR) begin
                                // ignore frames for other addresses
                                next_rw = sda_s;
                                next_state = (shreg[6:0] == my_addr) ? LDC_ADDR_ACK
                                    : LDC_IDLE;
                            end else if (state == LDC_PTR) begin
                                next_ptr = wbyte;
                                next_state = LDC_PTR_ACK;
                            end else begin
                                // data byte: write strobe, pointer advances
                                next_wr_en = 1'b1;
                                next_wr_addr = ptr;
                                next_wr_data = wbyte;
                                next_ptr = ptr + 8'h01;
                                if (ptr == CFG1_OFFSET && password_ok) begin
                                    // running conversion dropped [R1]
                                    next_adc_abort = 1'b1;
                                    next_cfg1_dirty = 1'b1;
                                end
                                next_state = LDC_WDATA_ACK;
                            end
                        end
                    end
                end
                LDC_ADDR_ACK, LDC_PTR_ACK, LDC_WDATA_ACK: begin
                    // pull data low for one clock period of the bus;
                    // locked writes are acked too, the host sees no refusal
                    if (scl_fall) begin
                        if (!ack_half) begin
                            next_sda_oe = 1'b1;
                            next_ack_half = 1'b1;
                        end else begin
                            next_sda_oe = 1'b0;
                            next_ack_half = 1'b0;
                            next_bit_cnt = 3'h0;
                            if (state == LDC_ADDR_ACK && rw) begin
                                // read frame: present first byte at once
                                next_shreg = read_byte(ptr, cfg1, cfg2, password_ok);
                                next_sda_oe = ~next_shreg[7];
                                next_state = LDC_RDATA;
                            end else if (state == LDC_ADDR_ACK) begin
                                next_state = LDC_PTR;
                            end else begin
                                next_state = LDC_WDATA;
                            end
                        end
                    end
                end
                LDC_RDATA: begin
                    // host samples on rise, next bit placed on fall
                    if (scl_rise) begin
                        next_bit_cnt = bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7) begin
                            next_ptr = ptr + 8'h01;
                            next_ack_half = 1'b0;
                            next_state = LDC_RDATA_ACK;
                        end
                    end else if (scl_fall) begin
                        next_shreg = {shreg[6:0], 1'b0};
                        next_sda_oe = ~shreg[6];
                    end
                end
                LDC_RDATA_ACK: begin
                    // release for the host's ack, then continue or stop
                    if (scl_fall && !ack_half) begin
                        next_sda_oe = 1'b0;
                        next_ack_half = 1'b1;
                    end else if (scl_rise && ack_half) begin
                        next_master_nack = sda_s;
                    end else if (scl_fall && ack_half) begin
                        next_ack_half = 1'b0;
                        next_bit_cnt = 3'h0;
                        if (master_nack) begin
                            next_state = LDC_IDLE;
                        end else begin
                            next_shreg = read_byte(ptr, cfg1, cfg2, password_ok);
                            next_sda_oe = ~next_shreg[7];
                            next_state = LDC_RDATA;
                        end
                    end
                end
            endcase
        end
    end

    // register the slave and the pin history
    always_ff @(posedge clk) begin
        if (!rstn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            state <= LDC_IDLE;
            bit_cnt <= 3'h0;
            shreg <= 8'h00;
            ptr <= 8'h00;
            rw <= 1'b0;
            ack_half <= 1'b0;
            master_nack <= 1'b0;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
            cfg1_dirty <= 1'b0;
            adc_abort <= 1'b0;
            adc_restart <= 1'b0;
            shutdown_output <= 1'b0;
            wr_en <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            ptr <= next_ptr;
            rw <= next_rw;
            ack_half <= next_ack_half;
            master_nack <= next_master_nack;
            sda_oe <= next_sda_oe;
            sda_out <= 1'b0; // open drain: only ever pulls low
            cfg1_dirty <= next_cfg1_dirty;
            adc_abort <= next_adc_abort;
            adc_restart <= next_adc_restart;
            shutdown_output <= next_shutdown_output;
            wr_en <= next_wr_en;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
        end
    end
endmodule // ldc_top

// *** sim/ldc_host.sv ***
// ldc_host: 2-wire management bus host that drives the config bank.
// assumes a pulled-up data line resolved outside; released means 1.
`timescale 1ns/10ps
module ldc_host #(
    parameter int H = 10 // half period of scl in clk cycles
) (
    // clock
    input wire logic clk,
    // resolved data line
    input wire logic sda,
    // open-drain drives, 1 = released
    output logic scl,
    output logic sda_o,
    // strobe for each byte read back
    output logic rd_valid,
    output logic [7:0] rd_data
);
    initial begin
        scl = 1'b1;
        sda_o = 1'b1;
        rd_valid = 1'b0;
        rd_data = 8'h00;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask
    // data moves mid-low, so it never changes while scl is high
    task automatic bitx(input logic b, output logic r);
        w(4);
        sda_o <= b;
        w(H - 4);
        scl <= 1'b1;
        w(H);
        r = sda;
        scl <= 1'b0;
    endtask
    // start when a=1 b=0, stop when a=0 b=1
    task automatic edge2(input logic a, input logic b);
        w(4);
        sda_o <= a;
        w(H - 4);
        scl <= 1'b1;
        w(H);
        sda_o <= b;
        w(H);
    endtask
    task automatic tx(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(b[i], r);
        bitx(1'b1, r);
        ack = !r;
    endtask
    // last byte is answered with a nack
    task automatic rx(input logic last);
        logic r;
        logic [7:0] v;
        for (int i = 0; i < 8; i++) begin
            bitx(1'b1, r);
            v = {v[6:0], r};
        end
        bitx(last, r);
        rd_data <= v;
        rd_valid <= 1'b1;
        @(posedge clk);
        rd_valid <= 1'b0;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
        output logic ok);
        logic k1, k2, k3;
        edge2(1'b1, 1'b0);
        scl <= 1'b0;
        tx({a, 1'b0}, k1);
        tx(p, k2);
        tx(d, k3);
        edge2(1'b0, 1'b1);
        ok = k1 & k2 & k3;
    endtask
    // pointer write, repeated start, one byte back
    task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic ok);
        logic k1, k2, k3;
        edge2(1'b1, 1'b0);
        scl <= 1'b0;
        tx({a, 1'b0}, k1);
        tx(p, k2);
        edge2(1'b1, 1'b0);
        scl <= 1'b0;
        tx({a, 1'b1}, k3);
        if (k3) rx(1'b1);
        edge2(1'b0, 1'b1);
        ok = k1 & k2 & k3;
    endtask
endmodule // ldc_host

// *** sim/ldc_top_asserts.sv ***
// ldc_top_asserts: timing relations at the ports of ldc_top.
// assumes password_ok only moves between bus frames.
`timescale 1ns/10ps
module ldc_top_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // control inputs
    input wire logic factory_init,
    input wire logic password_ok,
    input wire logic scl_in,
    input wire logic shutdown_request,
    // watched outputs
    input wire logic sda_oe,
    input wire logic adc_abort,
    input wire logic adc_restart,
    input wire logic shutdown_output,
    input wire logic apc_input_invert,
    input wire logic setpoint_swing_quarter,
    input wire logic feedback_reference_select,
    input wire logic [2:0] feedback_resistor_select,
    input wire logic bias_drive_direction,
    input wire logic shutdown_polarity,
    input wire logic [3:0] serial_address_high_nibble,
    input wire logic [2:0] reset_field_clear_delay
);
    logic [14:0] cfg; // every stored field except the spare bit
    assign cfg = {apc_input_invert, setpoint_swing_quarter, feedback_reference_select,
        feedback_resistor_select, bias_drive_direction, shutdown_polarity,
        serial_address_high_nibble, reset_field_clear_delay};
    // abort then restart once the frame stops
    sequence s_abort;
        adc_abort ##1 !adc_abort;
    endsequence
    sequence s_restart;
        ##[1:400] adc_restart;
    endsequence
    property p_reset_quiet;
        @(posedge clk) !rstn |=> !sda_oe && !adc_abort && !adc_restart && !shutdown_output;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy in reset");
    property p_nv_hold;
        @(posedge clk) !rstn && !factory_init |=> $stable(cfg);
    endproperty
    a_nv_hold: assert property (p_nv_hold) else $error("config moved in reset");
    property p_locked_hold;
        @(posedge clk) disable iff (!rstn)
            $changed(cfg) && !$past(factory_init) |-> $past(password_ok, 2);
    endproperty
    a_locked_hold: assert property (p_locked_hold) else $error("locked config changed");
    property p_abort_gated;
        @(posedge clk) disable iff (!rstn) adc_abort |-> $past(password_ok, 2);
    endproperty
    a_abort_gated: assert property (p_abort_gated) else $error("abort while locked");
    property p_abort_restart;
        @(posedge clk) disable iff (!rstn) s_abort |-> s_restart;
    endproperty
    a_abort_restart: assert property (p_abort_restart) else $error("no restart");
    property p_restart_pulse;
        @(posedge clk) disable iff (!rstn) adc_restart |=> !adc_restart [*4];
    endproperty
    a_restart_pulse: assert property (p_restart_pulse) else $error("restart repeated");
    property p_shutdown_output_level;
        @(posedge clk) disable iff (!rstn) $past(rstn) |->
            shutdown_output == ($past(shutdown_request) ~^ $past(shutdown_polarity));
    endproperty
    a_shutdown_output_level: assert property (p_shutdown_output_level) else $error("shutdown level wrong");
    property p_sda_scl_low;
        @(posedge clk) disable iff (!rstn) $changed(sda_oe) |-> !scl_in;
    endproperty
    a_sda_scl_low: assert property (p_sda_scl_low) else $error("sda moved, scl high");
endmodule // ldc_top_asserts

bind ldc_top ldc_top_asserts u_asserts (.*);

// *** sim/laser_drive_and_bus_address_config_tb.sv ***
// testbench: bus host model against ldc_top, reads scored by a queue.
// assumes the bank answers at 7'h53 after the factory load.
`timescale 1ns/10ps
module laser_drive_and_bus_address_config_tb;
    import ldc_pkg::*;
    logic clk = 0, rstn = 0, factory_init = 1, password_ok = 0, shutdown_request = 0;
    logic scl, sda_o, sda, sda_out, sda_oe, adc_abort, adc_restart, shutdown_output;
    logic rd_valid, ok;
    logic [7:0] rd_data, v, c1, c2;
    logic [6:0] dev = 7'h53; // current device address
    logic [7:0] exp_q[$];
    int seed = 32'he353, error_cnt = 0, checked = 0, n_ab = 0, n_rs = 0;
    ldc_cfg1_t f1;
    ldc_cfg2_t f2;
    // open drain: the device only ever pulls low
    assign sda = (sda_oe === 1'b1) ? (sda_out & sda_o) : sda_o;
    assign c1 = f1;
    assign c2 = {f2.serial_address_high_nibble, 1'b0, f2.reset_field_clear_delay};
    always #25 clk = ~clk;
    ldc_top DUT (.*, .scl_in(scl), .sda_in(sda),
        .apc_input_invert(f1.apc_input_invert),
        .setpoint_swing_quarter(f1.setpoint_swing_quarter),
        .feedback_reference_select(f1.feedback_reference_select),
        .feedback_resistor_select(f1.feedback_resistor_select),
        .bias_drive_direction(f1.bias_drive_direction),
        .shutdown_polarity(f1.shutdown_polarity),
        .serial_address_high_nibble(f2.serial_address_high_nibble),
        .reset_field_clear_delay(f2.reset_field_clear_delay));
    assign f2.spare = 1'b0;
    ldc_host u_host (.clk(clk), .sda(sda), .scl(scl), .sda_o(sda_o),
        .rd_valid(rd_valid), .rd_data(rd_data));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task finish_test;
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // write one byte, then count converter pulses it caused
    task automatic wcheck(input logic [7:0] p, input logic [7:0] d, input logic [7:0] ab);
        int a0 = n_ab;
        int r0 = n_rs;
        u_host.wr(dev, p, d, ok);
        repeat (8) @(posedge clk);
        chk("write ack", 8'h01, {7'h0, ok});
        chk("abort count", ab, 8'(n_ab - a0));
        chk("restart count", ab, 8'(n_rs - r0));
    endtask
    // note the expected byte, the watcher scores it
    task automatic rcheck(input logic [7:0] p, input logic [7:0] e);
        exp_q.push_back(e);
        u_host.rd(dev, p, ok);
        chk("read ack", 8'h01, {7'h0, ok});
    endtask
    // watcher: random shutdown requests, pulse counts, read scoring
    always @(posedge clk) begin
        shutdown_request <= $random(seed);
        n_ab += (adc_abort === 1'b1);
        n_rs += (adc_restart === 1'b1);
        if (rd_valid === 1'b1) chk("read data", exp_q.pop_front(), rd_data);
    end
    // hang guard
    initial begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        $display("CHECK FAILED run length expected end seen timeout");
        finish_test;
    end
    initial begin
        @(posedge clk);
        factory_init <= 1'b0;
        repeat (7) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        chk("cfg1 load", 8'h02, c1);
        chk("cfg2 load", 8'ha2, c2);
        $display("test load values done");
        // locked: reads empty, writes acked but dropped
        rcheck(8'h01, 8'h00);
        wcheck(8'h01, 8'hfd, 8'h00);
        chk("cfg1 locked", 8'h02, c1);
        $display("test locked done");
        password_ok <= 1'b1;
        @(posedge clk);
        rcheck(8'h01, 8'h02);
        rcheck(8'h02, 8'ha2);
        rcheck(8'h05, 8'h00);
        wcheck(8'h05, 8'hff, 8'h00);
        $display("test readback done");
        // every resistor code, then all zero and all one
        for (int i = 0; i < 10; i++) begin
            v = (i > 7) ? {8{i[0]}} : 8'($random(seed));
            if (i < 8) v[4:2] = i[2:0];
            wcheck(8'h01, v, 8'h01);
            chk("cfg1 fields", v, c1);
            rcheck(8'h01, v);
        end
        $display("test drive config done");
        rstn <= 1'b0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        chk("cfg1 after reset", 8'hff, c1);
        chk("cfg2 after reset", 8'ha2, c2);
        $display("test mid-run reset done");
        // new nibble answers at once, old address goes quiet
        for (int d = 0; d < 5; d++) begin
            v = {4'(5 + d), 1'b0, d[2:0]};
            wcheck(8'h02, v, 8'h00);
            chk("cfg2 fields", v, c2);
            dev = {v[7:4], 3'h3};
            rcheck(8'h02, v);
        end
        u_host.wr(7'h53, 8'h02, 8'ha2, ok);
        chk("old address ack", 8'h00, {7'h0, ok});
        chk("cfg2 kept", v, c2);
        $display("test address nibble done");
        finish_test;
    end
endmodule // laser_drive_and_bus_address_config_tb
